// ===== logic/lofg_top.sv
// latch-off fault guard: trip filtering, start-up gating, soft-start,
// thermal shutdown and an AXI4-Lite register slave with interrupt
// assumes asynchronous comparator and supply status pins
`timescale 1ns/1ps
`default_nettype none
module lofg_top
    import lofg_pkg::*;
#(
    parameter int UP_CYC   = lofg_pkg::UP_FILT_CYC,
    parameter int LOW_CYC  = lofg_pkg::LOW_FILT_CYC,
    parameter int STEP_CYC = lofg_pkg::SS_STEP_CYC
)
(
    input  wire logic                       clk_sys_i,
    input  wire logic                       nrst_i,
    input  wire lofg_pkg::lofg_pins_t       pins_i,
    output var  logic                       gate_drive_output_o,
    output var  logic                       boosted_bias_current_o,
    output var  logic                       hv_source_en_o,
    output var  logic                       latched_o,
    output var  logic [3:0]                 ss_setpoint_o,
    output var  logic                       irq_o,
    input  wire logic [lofg_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                       s_axi_awvalid_i,
    output var  logic                       s_axi_awready_o,
    input  wire logic [31:0]                s_axi_wdata_i,
    input  wire logic [3:0]                 s_axi_wstrb_i,
    input  wire logic                       s_axi_wvalid_i,
    output var  logic                       s_axi_wready_o,
    output var  logic [1:0]                 s_axi_bresp_o,
    output var  logic                       s_axi_bvalid_o,
    input  wire logic                       s_axi_bready_i,
    input  wire logic [lofg_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                       s_axi_arvalid_i,
    output var  logic                       s_axi_arready_o,
    output var  logic [31:0]                s_axi_rdata_o,
    output var  logic [1:0]                 s_axi_rresp_o,
    output var  logic                       s_axi_rvalid_o,
    input  wire logic                       s_axi_rready_i
);
    import lofg_pkg::*;

    lofg_state_t         state_reg;
    lofg_state_t         state_next;
    logic [SS_TMR_W-1:0] tmr_reg;
    logic [SS_TMR_W-1:0] tmr_next;
    logic [3:0]          step_next;
    logic                gate_next;
    logic                boost_next;
    logic                hv_next;
    logic                up_f;
    logic                low_f;
    logic                von_f;
    logic                vrst_f;
    logic                bo_f;
    logic                otp_f;
    logic                rst_cond;
    logic                trip_clr;
    logic [IRQ_W-1:0]    ev;

    ////////////////////////////////////////////////////////////////////////
    // pin filters
    assign rst_cond = bo_f | vrst_f;
    assign trip_clr = (state_reg == ST_OTSD) | rst_cond;

    lofg_filter #(.COUNT(UP_CYC)) u_up
    (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clr_i     (trip_clr),
        .pin_i     (pins_i.upper_trip),
        .level_o   (up_f)
    );
    lofg_filter #(.COUNT(LOW_CYC)) u_low
    (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clr_i     (trip_clr),
        .pin_i     (pins_i.lower_trip),
        .level_o   (low_f)
    );
    lofg_filter #(.COUNT(LEVEL_CYC)) u_von
    (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clr_i     (1'b0),
        .pin_i     (pins_i.vcc_on),
        .level_o   (von_f)
    );
    lofg_filter #(.COUNT(LEVEL_CYC)) u_vrst
    (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clr_i     (1'b0),
        .pin_i     (pins_i.vcc_reset),
        .level_o   (vrst_f)
    );
    lofg_filter #(.COUNT(LEVEL_CYC)) u_bo
    (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clr_i     (1'b0),
        .pin_i     (pins_i.brown_out),
        .level_o   (bo_f)
    );
    lofg_filter #(.COUNT(LEVEL_CYC)) u_otp
    (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .clr_i     (1'b0),
        .pin_i     (pins_i.over_temp),
        .level_o   (otp_f)
    );

    ////////////////////////////////////////////////////////////////////////
    // controller state, soft-start ramp and pin outputs
    logic run_bit_reg;

    always_comb
    begin
        state_next = state_reg;
        ev         = '0;
        case (state_reg)
            ST_WAIT:
                if (von_f)
                begin
                    if (up_f)
                    begin
                        state_next       = ST_LATCH;
                        ev[IRQ_UPPER]    = 1'b1;
                    end
                    else
                    begin
                        state_next       = ST_SSTART;
                        ev[IRQ_START]    = 1'b1;
                    end
                end
            ST_SSTART:
                if (up_f)
                begin
                    state_next    = ST_LATCH;
                    ev[IRQ_UPPER] = 1'b1;
                end
                else if (ss_setpoint_o == SS_TOP - 4'h1 && tmr_reg == SS_TMR_W'(STEP_CYC - 1))
                    state_next = ST_RUN;
            ST_RUN:
                if (up_f || low_f)
                begin
                    state_next    = ST_LATCH;
                    ev[IRQ_UPPER] = up_f;
                    ev[IRQ_LOWER] = ~up_f;
                end
            ST_LATCH:
                state_next = ST_LATCH;
            ST_OTSD:
                if (!otp_f)
                    state_next = ST_WAIT;
            default:
                state_next = ST_WAIT;
        endcase
        if (rst_cond && state_reg != ST_OTSD)
        begin
            state_next = ST_WAIT;
            ev         = '0;
        end
        if (otp_f)
        begin
            state_next    = ST_OTSD;
            ev            = '0;
            ev[IRQ_OTSD]  = (state_reg != ST_OTSD);
        end
        // ramp: one step each STEP_CYC, 15 steps to the limit
        tmr_next  = '0;
        step_next = 4'h0;
        if (state_next == ST_SSTART && state_reg == ST_SSTART)
        begin
            tmr_next  = tmr_reg + SS_TMR_W'(1);
            step_next = ss_setpoint_o;
            if (tmr_reg == SS_TMR_W'(STEP_CYC - 1))
            begin
                tmr_next  = '0;
                step_next = ss_setpoint_o + 4'h1;
            end
        end
        else if (state_next == ST_RUN)
            step_next = SS_TOP;
        gate_next  = run_bit_reg && (state_next == ST_SSTART || state_next == ST_RUN);
        boost_next = (state_next == ST_SSTART);
        hv_next    = (state_next != ST_OTSD);
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg              <= ST_WAIT;
            tmr_reg                <= '0;
            ss_setpoint_o          <= 4'h0;
            gate_drive_output_o    <= 1'b0;
            boosted_bias_current_o <= 1'b0;
            hv_source_en_o         <= 1'b1;
            latched_o              <= 1'b0;
        end
        else
        begin
            state_reg              <= state_next;
            tmr_reg                <= tmr_next;
            ss_setpoint_o          <= step_next;
            gate_drive_output_o    <= gate_next;
            boosted_bias_current_o <= boost_next;
            hv_source_en_o         <= hv_next;
            latched_o              <= (state_next == ST_LATCH);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave and interrupt registers
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [ADDR_W-1:0] aw_addr_next;
    logic              aw_held_reg;
    logic              aw_held_next;
    logic [31:0]       w_data_reg;
    logic [31:0]       w_data_next;
    logic              w_be0_reg;
    logic              w_be0_next;
    logic              w_held_reg;
    logic              w_held_next;
    logic              bvalid_next;
    logic [1:0]        bresp_next;
    logic              rvalid_next;
    logic [31:0]       rdata_next;
    logic [1:0]        rresp_next;
    logic              run_bit_next;
    logic [IRQ_W-1:0]  stat_reg;
    logic [IRQ_W-1:0]  stat_next;
    logic [IRQ_W-1:0]  mask_reg;
    logic [IRQ_W-1:0]  mask_next;
    logic [IRQ_W-1:0]  w1c;
    logic [31:0]       status_word;

    always_comb
    begin
        status_word                             = 32'h0;
        status_word[ST_STATE_LSB +: 3]          = state_reg;
        status_word[ST_GATE_BIT]                = gate_drive_output_o;
        status_word[ST_BOOST_BIT]               = boosted_bias_current_o;
        status_word[ST_HV_BIT]                  = hv_source_en_o;
        status_word[ST_UPPER_BIT]               = up_f;
        status_word[ST_LOWER_BIT]               = low_f;
        aw_held_next = aw_held_reg | (s_axi_awvalid_i & s_axi_awready_o);
        aw_addr_next = (s_axi_awvalid_i & s_axi_awready_o) ? s_axi_awaddr_i : aw_addr_reg;
        w_held_next  = w_held_reg | (s_axi_wvalid_i & s_axi_wready_o);
        w_data_next  = (s_axi_wvalid_i & s_axi_wready_o) ? s_axi_wdata_i : w_data_reg;
        w_be0_next   = (s_axi_wvalid_i & s_axi_wready_o) ? s_axi_wstrb_i[0] : w_be0_reg;
        bvalid_next  = s_axi_bvalid_o & ~s_axi_bready_i;
        bresp_next   = s_axi_bresp_o;
        run_bit_next = run_bit_reg;
        mask_next    = mask_reg;
        w1c          = '0;
        if (aw_held_next && w_held_next && !s_axi_bvalid_o)
        begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = RESP_OKAY;
            if (aw_addr_next == OFS_CTRL)
            begin
                if (w_be0_next)
                    run_bit_next = w_data_next[CTRL_RUN_BIT];
            end
            else if (aw_addr_next == OFS_IRQ_STAT)
            begin
                if (w_be0_next)
                    w1c = w_data_next[IRQ_W-1:0];
            end
            else if (aw_addr_next == OFS_IRQ_MASK)
            begin
                if (w_be0_next)
                    mask_next = w_data_next[IRQ_W-1:0];
            end
            else if (aw_addr_next != OFS_STATUS)
                bresp_next = RESP_SLVERR;
        end
        stat_next   = (stat_reg & ~w1c) | ev;
        rvalid_next = s_axi_rvalid_o & ~s_axi_rready_i;
        rdata_next  = s_axi_rdata_o;
        rresp_next  = s_axi_rresp_o;
        if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = 32'h0;
            if (s_axi_araddr_i == OFS_CTRL)
                rdata_next[CTRL_RUN_BIT] = run_bit_reg;
            else if (s_axi_araddr_i == OFS_STATUS)
                rdata_next = status_word;
            else if (s_axi_araddr_i == OFS_IRQ_STAT)
                rdata_next[IRQ_W-1:0] = stat_reg;
            else if (s_axi_araddr_i == OFS_IRQ_MASK)
                rdata_next[IRQ_W-1:0] = mask_reg;
            else
                rresp_next = RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            aw_addr_reg     <= '0;
            aw_held_reg     <= 1'b0;
            w_data_reg      <= 32'h0;
            w_be0_reg       <= 1'b0;
            w_held_reg      <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0;
            s_axi_rresp_o   <= RESP_OKAY;
            run_bit_reg     <= CTRL_RUN_RST;
            stat_reg        <= IRQ_RST;
            mask_reg        <= IRQ_RST;
            irq_o           <= 1'b0;
        end
        else
        begin
            aw_addr_reg     <= aw_addr_next;
            aw_held_reg     <= aw_held_next;
            w_data_reg      <= w_data_next;
            w_be0_reg       <= w_be0_next;
            w_held_reg      <= w_held_next;
            s_axi_awready_o <= ~aw_held_next & ~bvalid_next;
            s_axi_wready_o  <= ~w_held_next & ~bvalid_next;
            s_axi_bvalid_o  <= bvalid_next;
            s_axi_bresp_o   <= bresp_next;
            s_axi_arready_o <= ~rvalid_next;
            s_axi_rvalid_o  <= rvalid_next;
            s_axi_rdata_o   <= rdata_next;
            s_axi_rresp_o   <= rresp_next;
            run_bit_reg     <= run_bit_next;
            stat_reg        <= stat_next;
            mask_reg        <= mask_next;
            irq_o           <= |(stat_next & mask_next);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    property p_run_trip;
        (state_reg == ST_RUN && (up_f || low_f) && !rst_cond && !otp_f) |=> state_reg == ST_LATCH ##0 !gate_drive_output_o;
    endproperty
    a_run_trip: assert property (p_run_trip)
        else $error("trip in run did not latch off");

    property p_latch_hold;
        (state_reg == ST_LATCH && !rst_cond && !otp_f) |=> state_reg == ST_LATCH;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch left without brown-out or supply reset");

    property p_start_check;
        (state_reg == ST_WAIT && von_f && !rst_cond && !otp_f)
            |=> ($past(up_f) ? state_reg == ST_LATCH : state_reg == ST_SSTART);
    endproperty
    a_start_check: assert property (p_start_check)
        else $error("start level did not evaluate the upper trip");

    property p_low_ignored;
        (state_reg == ST_SSTART && !up_f && !rst_cond && !otp_f) |=> state_reg != ST_LATCH;
    endproperty
    a_low_ignored: assert property (p_low_ignored)
        else $error("lower trip acted during soft-start");

    property p_boost;
        boosted_bias_current_o == (state_reg == ST_SSTART);
    endproperty
    a_boost: assert property (p_boost)
        else $error("bias boost not aligned with soft-start");

    property p_otsd_stop;
        (otp_f && state_reg != ST_OTSD) |=> !gate_drive_output_o && !hv_source_en_o && ss_setpoint_o == 4'h0;
    endproperty
    a_otsd_stop: assert property (p_otsd_stop)
        else $error("thermal shutdown did not stop drive and source");

    property p_otsd_clear;
        state_reg == ST_OTSD |=> !up_f && !low_f && tmr_reg == '0;
    endproperty
    a_otsd_clear: assert property (p_otsd_clear)
        else $error("internal state not cleared in thermal shutdown");

    property p_otsd_exit;
        (state_reg == ST_OTSD && !otp_f) |=> state_reg == ST_WAIT && hv_source_en_o;
    endproperty
    a_otsd_exit: assert property (p_otsd_exit)
        else $error("thermal recovery did not restart normally");

    property p_ss_begin;
        (state_reg != ST_SSTART) ##1 (state_reg == ST_SSTART) |-> ss_setpoint_o == 4'h0 && tmr_reg == '0;
    endproperty
    a_ss_begin: assert property (p_ss_begin)
        else $error("soft-start did not begin from zero");

    property p_ramp_top;
        state_reg == ST_RUN |-> ss_setpoint_o == SS_TOP;
    endproperty
    a_ramp_top: assert property (p_ramp_top)
        else $error("run entered before 15 ramp steps");

    property p_latch_gate;
        state_reg == ST_LATCH |-> !gate_drive_output_o && latched_o;
    endproperty
    a_latch_gate: assert property (p_latch_gate)
        else $error("gate drive active while latched");
endmodule
`default_nettype wire

// ===== logic/lofg_pkg.sv
// constants, types and register map of the latch-off fault guard
// assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus
package lofg_pkg;
    // timing
    localparam int CLK_MHZ       = 125;
    localparam int UP_FILT_US    = 50;
    localparam int LOW_FILT_US   = 350;
    localparam int SSTART_US     = 4000;
    localparam int SS_STEPS      = 15;
    localparam int UP_FILT_CYC   = UP_FILT_US * CLK_MHZ;
    localparam int LOW_FILT_CYC  = LOW_FILT_US * CLK_MHZ;
    localparam int SS_STEP_CYC   = (SSTART_US * CLK_MHZ) / SS_STEPS;
    localparam int LEVEL_CYC     = 1;
    localparam int SS_TMR_W      = 20;
    // register map
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h0C;
    localparam int          CTRL_RUN_BIT = 0;
    localparam logic        CTRL_RUN_RST = 1'h1;
    localparam int          ST_STATE_LSB = 0;
    localparam int          ST_GATE_BIT  = 3;
    localparam int          ST_BOOST_BIT = 4;
    localparam int          ST_HV_BIT    = 5;
    localparam int          ST_UPPER_BIT = 6;
    localparam int          ST_LOWER_BIT = 7;
    localparam int          IRQ_W        = 4;
    localparam int          IRQ_UPPER    = 0;
    localparam int          IRQ_LOWER    = 1;
    localparam int          IRQ_OTSD     = 2;
    localparam int          IRQ_START    = 3;
    localparam logic [3:0]  IRQ_RST      = 4'h0;
    localparam logic [3:0]  SS_TOP       = 4'hF;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [2:0]
    {
        ST_WAIT   = 3'b000,
        ST_SSTART = 3'b001,
        ST_RUN    = 3'b010,
        ST_LATCH  = 3'b011,
        ST_OTSD   = 3'b100
    } lofg_state_t;

    typedef struct packed
    {
        logic upper_trip;
        logic lower_trip;
        logic vcc_on;
        logic vcc_reset;
        logic brown_out;
        logic over_temp;
    } lofg_pins_t;
endpackage

// ===== logic/lofg_filter.sv
// three-stage synchroniser and persistence filter for one pin
// assumes an asynchronous pin; output rises after COUNT stable high samples
`timescale 1ns/1ps
`default_nettype none
module lofg_filter
#(
    parameter int COUNT = 1
)
(
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic clr_i,
    input  wire logic pin_i,
    output var  logic level_o
);
    import lofg_pkg::*;
    localparam int CW = $clog2(COUNT + 1);

    logic          s1_reg;
    logic          s2_reg;
    logic          s3_reg;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          lvl_next;

    ////////////////////////////////////////////////////////////////////////
    // persistence count: second and third stage must agree
    always_comb
    begin
        cnt_next = cnt_reg;
        if (clr_i || (!s2_reg && !s3_reg))
            cnt_next = '0;
        else if (s2_reg && s3_reg && cnt_reg != CW'(COUNT))
            cnt_next = cnt_reg + CW'(1);
        lvl_next = (cnt_next == CW'(COUNT));
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1_reg  <= 1'b0;
            s2_reg  <= 1'b0;
            s3_reg  <= 1'b0;
            cnt_reg <= '0;
            level_o <= 1'b0;
        end
        else
        begin
            s1_reg  <= pin_i;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            cnt_reg <= cnt_next;
            level_o <= lvl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_short_ignored;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (!level_o && cnt_reg < CW'(COUNT - 1)) |=> !level_o;
    endproperty
    a_short_ignored: assert property (p_short_ignored)
        else $error("filter output rose before the full persistence time");
endmodule
`default_nettype wire

// ===== verif/lofg_sense_model.sv
// sense network model: drives both trip comparator levels
// assumes trips idle low; the bench sets levels via drive()
`timescale 1ns/1ps
`default_nettype none
module lofg_sense_model
(
    input  wire logic clk_sys_i,
    output var  logic upper_trip_o,
    output var  logic lower_trip_o
);
    initial
    begin
        upper_trip_o = 1'b0;
        lower_trip_o = 1'b0;
    end
    task automatic drive(input logic up, input logic lo);
        @(posedge clk_sys_i);
        upper_trip_o <= up;
        lower_trip_o <= lo;
    endtask
endmodule
`default_nettype wire

// ===== verif/latch_off_fault_guard_test.sv
// self-checking bench of the latch-off fault guard
// assumes the sense model drives the trip levels
`timescale 1ns/1ps
`default_nettype none
module latch_off_fault_guard_test;
    import lofg_pkg::*;
    logic        clk_sys_i, nrst_i, vcc_on, vcc_rst, bo, ot;
    logic        awv, awr, wv, wr, bv, brdy, arv, arr, rv, rrdy;
    logic        gate, boost, hv, latched, irq;
    wire logic   up, lo;
    logic [1:0]  br, rr;
    logic [3:0]  sp, ws;
    logic [7:0]  aw, ar;
    logic [31:0] wd, rd;
    lofg_pins_t  pins;
    int          error_cnt = 0;
    int          num_checks = 0;
    assign pins = {up, lo, vcc_on, vcc_rst, bo, ot};
    lofg_top #(.UP_CYC(8), .LOW_CYC(20), .STEP_CYC(4)) uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .pins_i(pins), .gate_drive_output_o(gate), .boosted_bias_current_o(boost), .hv_source_en_o(hv),
        .latched_o(latched), .ss_setpoint_o(sp), .irq_o(irq), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
        .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
        .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy));
    lofg_sense_model net (.clk_sys_i(clk_sys_i), .upper_trip_o(up), .lower_trip_o(lo));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return gate;
            1: return latched;
            2: return boost;
            default: return hv;
        endcase
    endfunction
    task automatic wait_on(input int s, input logic v, input int lim);
        int n = 0;
        while (pick(s) !== v && n < lim)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        chk1(pick(s), v);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge clk_sys_i);
        aw <= a;
        wd <= d;
        ws <= 4'hF;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
            n++;
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv && n < 50);
        brdy <= 1'b0;
        chk1(bv, 1'b1);
        chk({30'h0, br}, {30'h0, er});
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        @(posedge clk_sys_i);
        ar <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
            n++;
            if (arr) arv <= 1'b0;
        end while (!rv && n < 50);
        rrdy <= 1'b0;
        chk1(rv, 1'b1);
        chk(rd, ed);
        chk({30'h0, rr}, {30'h0, er});
    endtask
    ////////////////////////////////////////
    task automatic t_start_gate();
        axi_rd(OFS_CTRL, 32'h1, RESP_OKAY);
        axi_rd(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
        axi_wr(8'h40, 32'h1, RESP_SLVERR);
        net.drive(1'b1, 1'b0);
        repeat (20) @(posedge clk_sys_i);
        chk1(latched, 1'b0);
        vcc_on <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        chk1(gate, 1'b0);
        chk1(latched, 1'b1);
        net.drive(1'b0, 1'b0);
        repeat (30) @(posedge clk_sys_i);
        chk1(latched, 1'b1);
        bo <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        bo <= 1'b0;
        wait_on(1, 1'b0, 20);
    endtask
    task automatic t_soft_start();
        int n;
        wait_on(0, 1'b1, 40);
        chk1(boost, 1'b1);
        net.drive(1'b0, 1'b1);
        repeat (30) @(posedge clk_sys_i);
        net.drive(1'b0, 1'b0);
        n = 32;
        while (boost === 1'b1 && n < 90)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        chk1(n >= 59 && n <= 63, 1'b1);
        repeat (10) @(posedge clk_sys_i);
        chk({28'h0, sp}, 32'hF);
        chk1(latched, 1'b0);
        chk1(gate, 1'b1);
    endtask
    task automatic t_filters();
        net.drive(1'b1, 1'b0);
        repeat (5) @(posedge clk_sys_i);
        net.drive(1'b0, 1'b1);
        repeat (16) @(posedge clk_sys_i);
        net.drive(1'b0, 1'b0);
        repeat (20) @(posedge clk_sys_i);
        chk1(latched, 1'b0);
        axi_rd(OFS_STATUS, 32'h2A, RESP_OKAY);
        axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
        repeat (2) @(posedge clk_sys_i);
        chk1(gate, 1'b0);
        axi_rd(OFS_CTRL, 32'h0, RESP_OKAY);
        axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
        wait_on(0, 1'b1, 4);
    endtask
    task automatic t_latch_irq();
        axi_wr(OFS_IRQ_STAT, 32'hF, RESP_OKAY);
        axi_wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
        chk1(irq, 1'b0);
        net.drive(1'b1, 1'b0);
        wait_on(1, 1'b1, 30);
        chk1(gate, 1'b0);
        net.drive(1'b0, 1'b0);
        repeat (3) @(posedge clk_sys_i);
        chk1(irq, 1'b1);
        axi_rd(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
        repeat (50) @(posedge clk_sys_i);
        chk1(latched & ~gate, 1'b1);
        axi_wr(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
        repeat (3) @(posedge clk_sys_i);
        chk1(irq, 1'b0);
        vcc_rst <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        vcc_rst <= 1'b0;
        wait_on(1, 1'b0, 20);
        wait_on(0, 1'b1, 40);
        wait_on(2, 1'b0, 90);
    endtask
    task automatic t_thermal();
        ot <= 1'b1;
        wait_on(0, 1'b0, 8);
        chk1(hv, 1'b0);
        chk({28'h0, sp}, 32'h0);
        axi_rd(OFS_STATUS, 32'h4, RESP_OKAY);
        ot <= 1'b0;
        wait_on(3, 1'b1, 20);
        wait_on(0, 1'b1, 40);
        chk1(boost, 1'b1);
        wait_on(2, 1'b0, 90);
        net.drive(1'b0, 1'b1);
        wait_on(1, 1'b1, 40);
        chk1(irq, 1'b0);
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        {nrst_i, vcc_on, vcc_rst, bo, ot, awv, wv, brdy, arv, rrdy} = '0;
        {aw, ar, wd, ws} = '0;
        repeat (5) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        t_start_gate();
        t_soft_start();
        t_filters();
        t_latch_irq();
        t_thermal();
        print_verdict();
    end
    initial
    begin
        #100000;
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
